/* File: hdl/bexc_pkg.sv */
// Shared constants and types for the bridge excitation phase driver
package bexc_pkg;
    // System clock rate and period
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

    // Non-overlap gap between the two phases, two master clock periods
    localparam int unsigned GAP_NS     = 200;
    localparam int unsigned GAP_CYC_RAW = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GAP_CYCLES  = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;

    // Dwell counter width and default dwell per phase
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned DWELL_DEFAULT  = 1024;

    typedef logic [CNT_W-1:0] bexc_cnt_t;

    localparam bexc_cnt_t CNT_ZERO  = 16'h0000;
    localparam bexc_cnt_t CNT_ONE   = 16'h0001;
    localparam bexc_cnt_t GAP_LOAD  = bexc_cnt_t'(GAP_CYCLES - 1);

    // Enable input synchroniser depth
    localparam int unsigned SYNC_W = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;

    // Idle output levels: normal excitation
    localparam logic PHASE_A_IDLE = 1'b1;
    localparam logic PHASE_B_IDLE = 1'b0;

    typedef enum logic [1:0] {
        BEXC_NORMAL,
        BEXC_GAP_TO_REV,
        BEXC_REVERSED,
        BEXC_GAP_TO_NORM
    } bexc_state_e;
endpackage

/* File: hdl/bexc_down_counter.sv */
// Loadable down counter with zero flag, frozen by the clock enable
`timescale 1ns/1ps
module bexc_down_counter (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             clk_en_i,
    input  wire logic             load_i,
    input  wire bexc_pkg::bexc_cnt_t load_value_i,
    output logic                  done_o
);
    import bexc_pkg::*;

    typedef struct packed {
        bexc_cnt_t cnt;
    } bexc_cnt_s;

    bexc_cnt_s r;
    bexc_cnt_s next_r;

    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.cnt = load_value_i;
        end else if (r.cnt != CNT_ZERO) begin
            next_r.cnt = r.cnt - CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r.cnt <= CNT_ZERO;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    assign done_o = (r.cnt == CNT_ZERO);
endmodule

/* File: hdl/bexc_phase_driver.sv */
// Bridge excitation phase driver: two non-overlapping phases and their inverses
`timescale 1ns/1ps
// Function
// RULE1 - Enabled: phase b toggles opposite phase a
// RULE2 - Phases never overlap; gap one master period (the code holds both low for GAP_CYCLES, two periods)
// RULE3 - Disabled: phase b held low
// RULE4 - Phase b complement always inverse of b
// RULE5 - Disabled: phase b complement held high
// RULE6 - Phase a high normal, low reversed
// RULE7 - Disabled: phase a held high
// RULE8 - Phase a complement always inverse of a
// RULE9 - Disabled: phase a complement held low
// RULE10 - All transitions on master clock edges
module bexc_phase_driver #(
    parameter int unsigned DWELL_CYCLES = bexc_pkg::DWELL_DEFAULT
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic clk_en_i,
    input  wire logic ac_excite_enable_i,
    output logic      excite_phase_a_o,
    output logic      excite_phase_a_n_o,
    output logic      excite_phase_b_o,
    output logic      excite_phase_b_n_o,
    output logic      excite_active_o
);
    import bexc_pkg::*;

    localparam bexc_cnt_t DWELL_LOAD = bexc_cnt_t'(DWELL_CYCLES - 1);

    typedef struct packed {
        logic [SYNC_W-1:0] sync;
        logic              enable;
        bexc_state_e       state;
        logic              phase_a;
        logic              phase_a_n;
        logic              phase_b;
        logic              phase_b_n;
        logic              active;
    } bexc_drv_s;

    bexc_drv_s r;
    bexc_drv_s next_r;
    logic      dwell_load;
    logic      dwell_done;
    logic      gap_load;
    logic      gap_done;

    // Times each phase is held before the next reversal
    bexc_down_counter u_dwell (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .clk_en_i     (clk_en_i),
        .load_i       (dwell_load),
        .load_value_i (DWELL_LOAD),
        .done_o       (dwell_done)
    );

    // Times the interval in which both phases are low
    bexc_down_counter u_gap (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .clk_en_i     (clk_en_i),
        .load_i       (gap_load),
        .load_value_i (GAP_LOAD),
        .done_o       (gap_done)
    );

    always_comb begin
        next_r     = r;
        dwell_load = 1'b0;
        gap_load   = 1'b0;

        // Enable comes from another domain; accept only once two stages agree
        next_r.sync = {r.sync[SYNC_W-2:0], ac_excite_enable_i};
        if (r.sync[SYNC_W-2] == r.sync[SYNC_W-1]) begin
            next_r.enable = r.sync[SYNC_W-1];
        end

        unique case (r.state)
            BEXC_NORMAL: begin
                if (!r.enable) begin
                    // Restart dwell so the first reversal gets a full normal phase
                    dwell_load = 1'b1;
                end else if (dwell_done) begin
                    next_r.phase_a = 1'b0;                   // [RULE1] [RULE6]
                    next_r.state   = BEXC_GAP_TO_REV;
                    gap_load       = 1'b1;                   // [RULE2]
                end
            end
            BEXC_GAP_TO_REV: begin
                if (gap_done) begin
                    if (r.enable) begin
                        next_r.phase_b = 1'b1;               // [RULE1] [RULE2]
                        next_r.state   = BEXC_REVERSED;
                    end else begin
                        // Enable dropped during the gap: fall back to normal
                        next_r.phase_a = PHASE_A_IDLE;       // [RULE7]
                        next_r.state   = BEXC_NORMAL;
                    end
                    dwell_load = 1'b1;
                end
            end
            BEXC_REVERSED: begin
                // Leaving reversal still honours the gap before a returns high
                if (!r.enable || dwell_done) begin
                    next_r.phase_b = PHASE_B_IDLE;           // [RULE1] [RULE3]
                    next_r.state   = BEXC_GAP_TO_NORM;
                    gap_load       = 1'b1;                   // [RULE2]
                end
            end
            BEXC_GAP_TO_NORM: begin
                if (gap_done) begin
                    next_r.phase_a = PHASE_A_IDLE;           // [RULE2] [RULE6] [RULE7]
                    next_r.state   = BEXC_NORMAL;
                    dwell_load     = 1'b1;
                end
            end
        endcase

        // Complements are registered in the same edge as their phase
        next_r.phase_a_n = ~next_r.phase_a;                  // [RULE8] [RULE9]
        next_r.phase_b_n = ~next_r.phase_b;                  // [RULE4] [RULE5]
        next_r.active    = (next_r.state != BEXC_NORMAL);
    end

    // Every output changes only on a clock edge
    always_ff @(posedge clk_sys_i) begin                     // [RULE10]
        if (rst_i) begin
            r.sync      <= SYNC_RST;
            r.enable    <= 1'b0;
            r.state     <= BEXC_NORMAL;
            r.phase_a   <= PHASE_A_IDLE;                     // [RULE7]
            r.phase_a_n <= ~PHASE_A_IDLE;                    // [RULE9]
            r.phase_b   <= PHASE_B_IDLE;                     // [RULE3]
            r.phase_b_n <= ~PHASE_B_IDLE;                    // [RULE5]
            r.active    <= 1'b0;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    assign excite_phase_a_o   = r.phase_a;
    assign excite_phase_a_n_o = r.phase_a_n;
    assign excite_phase_b_o   = r.phase_b;
    assign excite_phase_b_n_o = r.phase_b_n;
    assign excite_active_o    = r.active;
endmodule

/* File: testbench/bexc_bridge_model.sv */
// Behavioural model of the switches that reverse the bridge excitation
`timescale 1ns/1ps
module bexc_bridge_model (
    input  wire logic clk_sys_i,
    input  wire logic phase_a_i,
    input  wire logic phase_b_i,
    output logic      reversed_o,
    output logic      shorted_o
);
    initial begin
        reversed_o = 1'b0;
        shorted_o  = 1'b0;
    end
    // Both switch pairs closed at once would short the supply, so it is latched
    always @(posedge clk_sys_i) begin
        if (phase_a_i && phase_b_i)
            shorted_o <= 1'b1;
        if (phase_a_i || phase_b_i)
            reversed_o <= phase_b_i;
    end
endmodule

/* File: testbench/bexc_phase_monitor.sv */
// Concurrent checks on the phase driver ports
`timescale 1ns/1ps
module bexc_phase_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic ac_excite_enable_i,
    input wire logic excite_phase_a_o,
    input wire logic excite_phase_a_n_o,
    input wire logic excite_phase_b_o,
    input wire logic excite_phase_b_n_o,
    input wire logic excite_active_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    AST_A_INV: assert property (excite_phase_a_n_o == !excite_phase_a_o)
        else $error("phase a complement wrong");
    AST_B_INV: assert property (excite_phase_b_n_o == !excite_phase_b_o)
        else $error("phase b complement wrong");
    AST_NO_OVL: assert property (!(excite_phase_a_o && excite_phase_b_o))
        else $error("phases overlap");
    AST_GAP_B: assert property ($rose(excite_phase_b_o) |-> !$past(excite_phase_a_o, 2))
        else $error("gap before b too short");
    AST_GAP_A: assert property (!$past(rst_i) && $rose(excite_phase_a_o) |-> !$past(excite_phase_b_o, 2))
        else $error("gap before a too short");
    AST_ANTI: assert property ($fell(excite_phase_b_o) && clk_en_i ##1 clk_en_i |=> excite_phase_a_o)
        else $error("a did not follow b");
    AST_DIS: assert property ((!ac_excite_enable_i && clk_en_i) [*8] |->
        excite_phase_a_o && !excite_phase_a_n_o && !excite_phase_b_o && excite_phase_b_n_o)
        else $error("idle levels wrong");
    AST_ACT: assert property (excite_active_o == !excite_phase_a_o)
        else $error("active flag disagrees with a");
    AST_FRZ: assert property (!clk_en_i |=> $stable({excite_phase_a_o, excite_phase_b_o}))
        else $error("output moved without clock enable");
endmodule
bind bexc_phase_driver bexc_phase_monitor u_mon (.*);

/* File: testbench/tb.sv */
// Self-checking testbench for the bridge excitation phase driver
`timescale 1ns/1ps
module tb;
    import bexc_pkg::*;
    localparam int DW = 4;
    logic clk_sys_i = 1'b0;
    logic rst_i     = 1'b1;
    logic clk_en_i  = 1'b1;
    logic en        = 1'b0;
    logic a, a_n, b, b_n, act, rev, sh;
    int   failures    = 0;
    int   checks_done = 0;
    int   cyc         = 0;
    int   n;
    int   rows [4][3] = '{'{0, 0, GAP_CYCLES}, '{0, 1, DW}, '{0, 0, GAP_CYCLES}, '{1, 0, DW}};
    always #50 clk_sys_i = ~clk_sys_i;
    bexc_phase_driver #(.DWELL_CYCLES(DW)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
        .ac_excite_enable_i(en), .excite_phase_a_o(a), .excite_phase_a_n_o(a_n), .excite_phase_b_o(b),
        .excite_phase_b_n_o(b_n), .excite_active_o(act));
    bexc_bridge_model u_br (.clk_sys_i(clk_sys_i), .phase_a_i(a), .phase_b_i(b), .reversed_o(rev), .shorted_o(sh));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #10;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Waits for a phase state, then measures how long it stands
    task automatic hold(input int r);
        int w;
        w = 0;
        while ({a, b} !== 2'(rows[r][0] * 2 + rows[r][1]) && w < 50) begin
            step(1);
            w++;
        end
        n = 0;
        while ({a, b} === 2'(rows[r][0] * 2 + rows[r][1]) && n < 50) begin
            chk("inv", 16'({a_n, b_n}), 16'({~a, ~b}));
            step(1);
            n++;
        end
        chk("dwell", 16'(n), 16'(rows[r][2]));
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        step(20);
        chk("rst", 16'({a, a_n, b, b_n, act}), 16'h0012);
        rst_i = 1'b0;
        step(10);
        chk("idle", 16'({a, a_n, b, b_n, act}), 16'h0012);
        en = 1'b1;
        for (int i = 0; i < 8; i++)
            hold(i % 4);
        // Freeze in mid reversal: nothing may move while the clock enable is low
        step(2);
        clk_en_i = 1'b0;
        step(10);
        chk("frozen", 16'({a, a_n, b, b_n, act}), 16'h000D);
        chk("rev", 16'(rev), 16'h0001);
        clk_en_i = 1'b1;
        en = 1'b0;
        step(12);
        chk("off", 16'({a, a_n, b, b_n, act}), 16'h0012);
        chk("norm", 16'({rev, sh}), 16'h0000);
        en = 1'b1;
        step(11);
        rst_i = 1'b1;
        step(3);
        chk("rerst", 16'({a, a_n, b, b_n, act}), 16'h0012);
        rst_i = 1'b0;
        step(5);
        // Drop the enable so that it lands inside the gap before reversal
        en = 1'b0;
        step(3);
        chk("gapdrop", 16'({a, a_n, b, b_n, act}), 16'h000B);
        step(2);
        chk("gapback", 16'({a, a_n, b, b_n, act}), 16'h0012);
        end_sim();
    end
endmodule
